// ==== logic/preamble_detector.sv ====
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Purpose: preamble qualification with threshold, custom pattern and arrival detectors
// Assumes: bit stream and strength samples arrive from pins, resynchronised here
// Notes:   qualified output holds until software restarts the search
module preamble_detector
  import preamble_detector_pkg::*;
  (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // demodulated link side
  input  wire logic              rx_bit_i,
  input  wire logic              rx_bit_strobe_i,
  input  wire logic              signal_strength_measure_jump_i,
  // towards sync search
  output logic                   preamble_valid_o,
  output logic                   sync_search_o,
  output logic                   jump_reconfig_o,
  output logic                   irq_o
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           bit_s1;     // first stage, read only by second
    logic [2:0]           bit_s2;
    logic                 strobe_d;
    logic                 enable;
    logic                 arrival_en;
    logic                 fcorr_en;
    logic                 nstd_en;
    logic [THRESH_W-1:0]  thresh;
    logic [PLEN_W-1:0]    plen;
    logic [3:0]           nstd_rep;
    logic [PATTERN_W-1:0] pattern;
    logic [SIGNAL_STRENGTH_MEASURE_W-1:0]    jump_cfg;
    logic                 last_bit;
    logic                 have_last;
    logic [THRESH_W:0]    run_cnt;
    logic [PLEN_W:0]      nstd_bits;
    logic [3:0]           nstd_cnt;
    logic                 jump_seen;
    logic [4:0]           arr_cnt;
    det_state_type        state;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 valid;
    logic                 reconfig;
    logic                 irq;
    logic                 sync;       // registered copy of the sync-search state
  } state_type;

  state_type s_reg;
  state_type s_next;

  logic [PATTERN_W-1:0] hist;
  logic                 bit_now;
  logic                 bit_ev;
  logic                 jump_now;

  // newest synchronised samples
  assign bit_now  = s_reg.bit_s2[0];
  assign bit_ev   = s_reg.bit_s2[1] & ~s_reg.strobe_d;
  assign jump_now = s_reg.bit_s2[2];

  // custom pattern compare over the programmed length
  function automatic logic pattern_hit(input logic [PATTERN_W-1:0] h,
                                       input logic [PATTERN_W-1:0] p,
                                       input logic [PLEN_W-1:0]    len);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < PATTERN_W; i++)
    begin
      if (i <= int'(len) && h[i] != p[i])
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : pattern_hit

  // history of received bits for the custom pattern detector
  bit_history #(.DEPTH(PATTERN_W)) u_hist (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .clear_i     (s_reg.state == ST_SYNC_SEARCH),
    .bit_valid_i (bit_ev),
    .bit_i       (bit_now),
    .hist_o      (hist)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    logic                 wr;
    logic                 rd;
    logic                 restart;
    logic [IRQ_W-1:0]     ev;
    logic [THRESH_W:0]    run_n;
    s_next  = s_reg;
    wr      = psel & penable & pwrite;
    rd      = psel & ~penable & ~pwrite;
    restart = 1'b0;
    ev      = '0;
    run_n   = s_reg.run_cnt;

    // pins pass two flip-flops before use
    s_next.bit_s1   = {signal_strength_measure_jump_i, rx_bit_strobe_i, rx_bit_i};
    s_next.bit_s2   = s_reg.bit_s1;
    s_next.strobe_d = s_reg.bit_s2[1];

    // apb: every access answers in its first access cycle
    s_next.pready  = psel & ~penable;
    s_next.pslverr = 1'b0;
    if (rd)
    begin
      s_next.prdata = '0;
      case (paddr)
        CTRL_OFFSET:     s_next.prdata[4:0] = {s_reg.nstd_en, s_reg.fcorr_en,
                                               s_reg.arrival_en, 1'b0, s_reg.enable};
        STD_CFG_OFFSET:  s_next.prdata[THRESH_W-1:0] = s_reg.thresh;
        NSTD_CFG_OFFSET: s_next.prdata[11:0] = {s_reg.nstd_rep, 3'b000, s_reg.plen};
        PATTERN_OFFSET:  s_next.prdata = s_reg.pattern;
        JUMP_CFG_OFFSET: s_next.prdata[SIGNAL_STRENGTH_MEASURE_W-1:0] = s_reg.jump_cfg;
        STATUS_OFFSET:   s_next.prdata[9:0] = {s_reg.reconfig, s_reg.run_cnt, s_reg.valid};
        IRQ_STAT_OFFSET: s_next.prdata[IRQ_W-1:0] = s_reg.irq_stat;
        IRQ_MASK_OFFSET: s_next.prdata[IRQ_W-1:0] = s_reg.irq_mask;
        default:         s_next.pslverr = 1'b0;  // unmapped reads as zero
      endcase
    end
    if (psel & ~penable)
    begin
      s_next.pslverr = ~(paddr inside {CTRL_OFFSET, STD_CFG_OFFSET, NSTD_CFG_OFFSET,
                         PATTERN_OFFSET, JUMP_CFG_OFFSET, STATUS_OFFSET,
                         IRQ_STAT_OFFSET, IRQ_MASK_OFFSET});
    end
    if (wr && s_reg.pready)
    begin
      case (paddr)
        CTRL_OFFSET:
        begin
          s_next.enable     = pwdata[CTRL_ENABLE_BIT];
          s_next.arrival_en = pwdata[CTRL_ARRIVAL_BIT];
          s_next.fcorr_en   = pwdata[CTRL_FCORR_BIT];
          s_next.nstd_en    = pwdata[CTRL_NSTD_BIT];
          restart           = pwdata[CTRL_RESTART_BIT];
        end
        STD_CFG_OFFSET:  s_next.thresh = pwdata[THRESH_W-1:0];
        NSTD_CFG_OFFSET:
        begin
          s_next.plen     = pwdata[NSTD_LEN_LSB +: PLEN_W];
          s_next.nstd_rep = pwdata[NSTD_REP_LSB +: 4];
        end
        PATTERN_OFFSET:  s_next.pattern  = pwdata;
        JUMP_CFG_OFFSET:
        begin
          s_next.jump_cfg = pwdata[SIGNAL_STRENGTH_MEASURE_W-1:0];
          s_next.reconfig = 1'b0;
        end
        IRQ_MASK_OFFSET: s_next.irq_mask = pwdata[IRQ_W-1:0];
        default:         s_next.pslverr = 1'b0;  // error pulse must not outlive pready
      endcase
    end

    // detectors run only while searching
    case (s_reg.state)
      ST_SEARCH:
      begin
        if (s_reg.enable && bit_ev)
        begin
          // threshold detector on the alternating pattern, kept beside arrival
          if (s_reg.have_last && bit_now != s_reg.last_bit)
          begin
            if (s_reg.run_cnt != {1'b0, {THRESH_W{1'b1}}})
            begin
              run_n = s_reg.run_cnt + 1'b1;
            end
          end
          else
          begin
            run_n = (THRESH_W+1)'(1);
          end
          s_next.run_cnt   = run_n;
          s_next.last_bit  = bit_now;
          s_next.have_last = 1'b1;
          // zero threshold leaves qualification to sync search
          if (!s_reg.nstd_en && s_reg.thresh != '0 &&
              run_n >= {1'b0, s_reg.thresh})
          begin
            ev[IRQ_STD_BIT] = 1'b1;
          end
          // custom repeating pattern, one count per completed period
          if (s_reg.nstd_en)
          begin
            if (s_reg.nstd_bits == {1'b0, s_reg.plen})
            begin
              s_next.nstd_bits = '0;
              if (pattern_hit({hist[PATTERN_W-2:0], bit_now}, s_reg.pattern, s_reg.plen))
              begin
                s_next.nstd_cnt = s_reg.nstd_cnt + 1'b1;
                if (s_reg.nstd_cnt + 1'b1 >= s_reg.nstd_rep)
                begin
                  ev[IRQ_NSTD_BIT] = 1'b1;
                end
              end
              else
              begin
                s_next.nstd_cnt = '0;
              end
            end
            else
            begin
              s_next.nstd_bits = s_reg.nstd_bits + 1'b1;
            end
          end
          // arrival detector: jump seen, then alternation within the window
          if (s_reg.arrival_en && s_reg.jump_seen)
          begin
            s_next.arr_cnt = s_reg.arr_cnt + 1'b1;
            if (run_n >= {3'b000, (s_reg.fcorr_en ? ARRIVAL_BITS_FC : ARRIVAL_BITS)})
            begin
              ev[IRQ_ARRIVAL_BIT] = 1'b1;
            end
            else if (s_reg.arr_cnt == (s_reg.fcorr_en ? ARRIVAL_BITS_FC : ARRIVAL_BITS))
            begin
              s_next.jump_seen = 1'b0;
              s_next.arr_cnt   = '0;
            end
          end
        end
        // jump from the strength measurement opens an arrival window
        if (s_reg.enable && s_reg.arrival_en && jump_now && !s_reg.jump_seen)
        begin
          s_next.jump_seen = 1'b1;
          s_next.arr_cnt   = '0;
        end
        if (ev != '0)
        begin
          s_next.state    = ST_SYNC_SEARCH;
          s_next.valid    = 1'b1;
          s_next.reconfig = ev[IRQ_ARRIVAL_BIT];
        end
      end
      ST_SYNC_SEARCH:
      begin
        s_next.valid = 1'b1;
      end
      default:
      begin
        s_next.state = ST_SEARCH;
      end
    endcase

    // restart drops back to search and clears all counts
    if (restart || !s_next.enable)
    begin
      s_next.state     = ST_SEARCH;
      s_next.valid     = 1'b0;
      s_next.run_cnt   = '0;
      s_next.have_last = 1'b0;
      s_next.nstd_bits = '0;
      s_next.nstd_cnt  = '0;
      s_next.jump_seen = 1'b0;
      s_next.arr_cnt   = '0;
    end

    // sticky status: set wins over write-one-to-clear
    if (wr && s_reg.pready && paddr == IRQ_STAT_OFFSET)
    begin
      s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_W-1:0];
    end
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
    s_next.sync     = (s_next.state == ST_SYNC_SEARCH);
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_reg          <= '0;
      s_reg.state    <= ST_SEARCH;
      s_reg.thresh   <= THRESH_RESET;
      s_reg.plen     <= NSTD_LEN_RESET;
      s_reg.nstd_rep <= NSTD_REP_RESET;
      s_reg.jump_cfg <= JUMP_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata           = s_reg.prdata;
  assign pready           = s_reg.pready;
  assign pslverr          = s_reg.pslverr;
  assign preamble_valid_o = s_reg.valid;
  assign sync_search_o    = s_reg.sync;
  assign jump_reconfig_o  = s_reg.reconfig;
  assign irq_o            = s_reg.irq;

endmodule : preamble_detector

// ==== logic/preamble_detector_pkg.sv ====
// Purpose: constants and register map of the receive preamble detector
// Assumes: one system clock at 100 MHz, apb register access with 32-bit data
// Notes:   register offsets and layouts are local choices, see below
package preamble_detector_pkg;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] STD_CFG_OFFSET    = 8'h04;
  localparam logic [7:0] NSTD_CFG_OFFSET   = 8'h08;
  localparam logic [7:0] PATTERN_OFFSET    = 8'h0C;
  localparam logic [7:0] JUMP_CFG_OFFSET   = 8'h10;
  localparam logic [7:0] STATUS_OFFSET     = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFFSET   = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h1C;

  // ------------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------------
  localparam int          THRESH_W          = 7;
  localparam logic [6:0]  THRESH_RESET      = 7'h14;   // twenty bits
  localparam int          PATTERN_W         = 32;
  localparam int          PLEN_W            = 5;        // pattern length minus one
  localparam int          SIGNAL_STRENGTH_MEASURE_W            = 8;
  localparam logic [7:0]  JUMP_RESET        = 8'h0C;
  localparam int          CTRL_ENABLE_BIT   = 0;
  localparam int          CTRL_RESTART_BIT  = 1;
  localparam int          CTRL_ARRIVAL_BIT  = 2;
  localparam int          CTRL_FCORR_BIT    = 3;
  localparam int          CTRL_NSTD_BIT     = 4;
  localparam int          NSTD_LEN_LSB      = 0;
  localparam int          NSTD_REP_LSB      = 8;        // repeats required, 4 bits
  localparam logic [3:0]  NSTD_REP_RESET    = 4'h2;
  localparam logic [4:0]  NSTD_LEN_RESET    = 5'h07;

  // interrupt bit positions
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_STD_BIT       = 0;
  localparam int          IRQ_ARRIVAL_BIT   = 1;
  localparam int          IRQ_NSTD_BIT      = 2;

  // arrival window lengths in bits: one byte, two with frequency correction
  localparam logic [4:0]  ARRIVAL_BITS      = 5'd8;
  localparam logic [4:0]  ARRIVAL_BITS_FC   = 5'd16;

  typedef enum {
    ST_SEARCH,
    ST_SYNC_SEARCH
  } det_state_type;

endpackage : preamble_detector_pkg

// ==== logic/bit_history.sv ====
`timescale 1ns/1ps
// Purpose: shift register holding the last received bits, registered output
// Assumes: bit_valid_i is a one-cycle strobe in the system clock domain
// Notes:   used to compare incoming bits against the custom repeating pattern
module bit_history
  #(parameter int DEPTH = 32)
  (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clear_i,
  input  wire logic              bit_valid_i,
  input  wire logic              bit_i,
  output logic [DEPTH-1:0]       hist_o
  );

  // shift in newest bit at the low end
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || clear_i)
    begin
      hist_o <= '0;
    end
    else if (bit_valid_i)
    begin
      hist_o <= {hist_o[DEPTH-2:0], bit_i};
    end
  end

endmodule : bit_history

// ==== verif/preamble_detector_asserts.sv ====
// Purpose: port checks on the preamble detector
// Assumes: apb slave answers one cycle after the setup cycle
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
module preamble_detector_asserts
  import preamble_detector_pkg::*;
  (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_bit_i,
  input wire logic        rx_bit_strobe_i,
  input wire logic        signal_strength_measure_jump_i,
  input wire logic        preamble_valid_o,
  input wire logic        sync_search_o,
  input wire logic        jump_reconfig_o,
  input wire logic        irq_o
  );
  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  logic       wr_any;
  logic       wr_any_reg;
  logic [4:0] age_reg;
  assign wr_any = psel && penable && pready && pwrite;
  // a write may drop a flag one edge late; age counts clocks since a bit stood on the pin
  always_ff @(posedge clk_sys_i)
  begin
    wr_any_reg <= sys_rst_i ? 1'b0 : wr_any;
    age_reg    <= (sys_rst_i || rx_bit_strobe_i) ? 5'h00 : age_reg + {4'h0, age_reg != 5'h1F};
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_ready_cause; pready |-> $past(psel && !penable); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready without setup");
  property p_ready_setup; psel && !penable |=> pready; endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("pready missing after setup");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  property p_valid_hold; preamble_valid_o && !wr_any && !wr_any_reg |=> preamble_valid_o; endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped");
  property p_valid_sync; $rose(preamble_valid_o) |-> ##[0:1] sync_search_o; endproperty
  a_valid_sync: assert property (p_valid_sync) else $error("no sync search");
  property p_valid_bit; $rose(preamble_valid_o) |-> age_reg < 5'd12; endproperty
  a_valid_bit: assert property (p_valid_bit) else $error("valid without a bit");
  property p_reconf_hold; jump_reconfig_o && !wr_any && !wr_any_reg |=> jump_reconfig_o; endproperty
  a_reconf_hold: assert property (p_reconf_hold) else $error("reconfig dropped");
endmodule : preamble_detector_asserts

// ==== verif/link_tx_model.sv ====
// Purpose: remote transmitter model sending one bit per request
// Assumes: the bench asks for one bit at a time
// Notes:   data line shows the inverse bit once its hold has run out
`timescale 1ns/1ps
module link_tx_model
  (
  input  wire logic clk_sys_i,
  input  wire logic send_i,
  input  wire logic bit_i,
  output logic      rx_bit_o,
  output logic      rx_bit_strobe_o,
  output logic      busy_o
  );
  logic [3:0] cnt_reg;
  initial
  begin
    rx_bit_o        = 1'b0;
    rx_bit_strobe_o = 1'b0;
    busy_o          = 1'b0;
    cnt_reg         = 4'h0;
  end
  // bit and strobe stand four clocks, then four quiet clocks keep the spacing legal
  always @(posedge clk_sys_i)
  begin
    if (send_i && !busy_o)
    begin
      rx_bit_o        <= bit_i;
      rx_bit_strobe_o <= 1'b1;
      busy_o          <= 1'b1;
      cnt_reg         <= 4'h8;
    end
    else if (busy_o)
    begin
      cnt_reg <= cnt_reg - 4'h1;
      if (cnt_reg == 4'h5)
      begin
        rx_bit_strobe_o <= 1'b0;
        rx_bit_o        <= ~rx_bit_o; // stale bit must not look valid
      end
      busy_o <= (cnt_reg != 4'h1);
    end
  end
endmodule : link_tx_model

// ==== verif/testbench.sv ====
// Purpose: self-checking bench for the preamble detector
// Assumes: wait-free apb, bits spaced by the link model
// Notes:   threshold drawn at random from a fixed seed
`timescale 1ns/1ps
module testbench
  import preamble_detector_pkg::*;
  ;
  logic        clk_sys_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        signal_strength_measure_jump_i = 1'b0;
  logic        send = 1'b0;
  logic        tx_bit = 1'b0;
  logic        last = 1'b0;
  logic [31:0] prdata, rd_data;
  logic        pready, pslverr, rx_bit_i, rx_bit_strobe_i, busy, rd_err;
  logic        preamble_valid_o, sync_search_o, jump_reconfig_o, irq_o;
  int          num_errors = 0;
  int          check_count = 0;
  int          seed = 32'h06d6;
  int          th;
  // 100 MHz system clock
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  preamble_detector i_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_bit_i(rx_bit_i), .signal_strength_measure_jump_i(signal_strength_measure_jump_i),
    .rx_bit_strobe_i(rx_bit_strobe_i), .preamble_valid_o(preamble_valid_o),
    .sync_search_o(sync_search_o), .jump_reconfig_o(jump_reconfig_o), .irq_o(irq_o));
  link_tx_model i_tx (.clk_sys_i(clk_sys_i), .send_i(send), .bit_i(tx_bit),
    .rx_bit_o(rx_bit_i), .rx_bit_strobe_o(rx_bit_strobe_i), .busy_o(busy));
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // one apb transfer; read data and error land in rd_data and rd_err
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) num_errors++;
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic send_bit(input logic b);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    send   <= 1'b1;
    tx_bit <= b;
    last = b;
    // hold the request until the model shows it has taken the bit
    do
    begin
      @(posedge clk_sys_i);
      n++;
    end
    while (busy !== 1'b1 && n < 40);
    send <= 1'b0;
    while (busy === 1'b1 && n < 40)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 40) num_errors++;
  endtask : send_bit
  // alternating bits continuing from the last one sent
  task automatic run(input int n);
    repeat (n) send_bit(~last);
  endtask : run
  task automatic settle;
    repeat (4) @(posedge clk_sys_i);
  endtask : settle
  // hang guard, far beyond the thousand or so clocks the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    num_errors++;
    summarize;
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("valid after reset", preamble_valid_o, 1'b0);
    chk("irq after reset", irq_o, 1'b0);
    apb(1'b0, STD_CFG_OFFSET, 32'h0);
    chk("threshold reset", rd_data, {25'h0, THRESH_RESET});
    apb(1'b0, NSTD_CFG_OFFSET, 32'h0);
    chk("pattern cfg reset", rd_data, {20'h0, NSTD_REP_RESET, 3'h0, NSTD_LEN_RESET});
    apb(1'b0, JUMP_CFG_OFFSET, 32'h0);
    chk("jump cfg reset", rd_data, {24'h0, JUMP_RESET});
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped error", rd_err, 1'b1);
    chk("unmapped data", rd_data, 32'h0);
    // threshold detector beside an idle arrival detector, run broken once
    th = 4 + ($unsigned($random(seed)) % 9);
    apb(1'b1, STD_CFG_OFFSET, th);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h7);
    run(th - 1);
    send_bit(last);
    run(th - 2);
    settle;
    chk("valid after broken run", preamble_valid_o, 1'b0);
    run(1);
    settle;
    chk("valid at threshold", preamble_valid_o, 1'b1);
    chk("sync search", sync_search_o, 1'b1);
    chk("irq raised", irq_o, 1'b1);
    send_bit(last);
    run(3);
    chk("valid held", preamble_valid_o, 1'b1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status word", rd_data, {22'h0, 1'b0, th[7:0], 1'b1});
    apb(1'b0, IRQ_STAT_OFFSET, 32'h0);
    chk("irq status", rd_data, 32'h1);
    apb(1'b1, IRQ_STAT_OFFSET, 32'h1);
    settle;
    chk("irq cleared", irq_o, 1'b0);
    // custom pattern mode ignores a long alternating run
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0);
    apb(1'b1, PATTERN_OFFSET, 32'h0000000F);
    apb(1'b1, NSTD_CFG_OFFSET, 32'h203);
    apb(1'b1, CTRL_OFFSET, 32'h13);
    apb(1'b0, PATTERN_OFFSET, 32'h0);
    chk("pattern readback", rd_data, 32'h0000000F);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl readback", rd_data, 32'h00000011);
    run(24);
    settle;
    chk("alternating in custom mode", preamble_valid_o, 1'b0);
    repeat (16) send_bit(1'b1);
    settle;
    chk("custom pattern", preamble_valid_o, 1'b1);
    chk("masked irq", irq_o, 1'b0);
    apb(1'b0, IRQ_STAT_OFFSET, 32'h0);
    chk("custom irq status", rd_data, 32'h4);
    // arrival detector alone, one byte then two with correction
    apb(1'b1, STD_CFG_OFFSET, 32'h0);
    for (int fc = 0; fc < 2; fc++)
    begin
      apb(1'b1, CTRL_OFFSET, (fc != 0) ? 32'hF : 32'h7);
      signal_strength_measure_jump_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      signal_strength_measure_jump_i <= 1'b0;
      run((fc != 0) ? 15 : 7);
      settle;
      chk("arrival early", preamble_valid_o, 1'b0);
      run(1);
      settle;
      chk("arrival", preamble_valid_o, 1'b1);
      chk("jump reconfig", jump_reconfig_o, 1'b1);
      apb(1'b1, JUMP_CFG_OFFSET, {24'h0, JUMP_RESET});
      settle;
      chk("reconfig cleared", jump_reconfig_o, 1'b0);
    end
    summarize;
  end
endmodule : testbench
bind preamble_detector preamble_detector_asserts i_chk (.clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit_i(rx_bit_i),
  .rx_bit_strobe_i(rx_bit_strobe_i), .signal_strength_measure_jump_i(signal_strength_measure_jump_i), .irq_o(irq_o),
  .preamble_valid_o(preamble_valid_o), .sync_search_o(sync_search_o),
  .jump_reconfig_o(jump_reconfig_o));
